/* File: rtl/pin_override_consts.svh */
`ifndef PIN_OVERRIDE_CONSTS_SVH
`define PIN_OVERRIDE_CONSTS_SVH

// pin positions within the joined {port f, port e} vector
`define PIN_E_RX        0
`define PIN_E_TX        1
`define PIN_E_SYNC_CLK  2
`define PIN_E_CMP_NEG   3
`define PIN_E_USI_CLK   4
`define PIN_E_USI_DATA  5
`define PIN_E_USI_OUT   6
`define PIN_E_CLK_OUT   7
`define PIN_F_TDI       15
`define PIN_F_TDO       14
`define PIN_F_TMS       13
`define PIN_F_TCK       12
`define PORT_E_LSB      0
`define PORT_E_MSB      7
`define PORT_F_LSB      8
`define PORT_F_MSB      15

// reset values of the registered pin attributes
`define RST_PULLUP      16'hB000
`define RST_DIR         16'h0000
`define RST_OUT_VALUE   16'h0000
`define RST_TOGGLE      16'h0000
`define RST_INPUT_EN    16'h00FF
`define RST_ADC_ROUTE   8'hFF
`define OVR_NONE        16'h0000

`endif

/* File: rtl/pin_override_pkg.sv */
package pin_override_pkg;
    typedef logic [15:0] pin_vec_t;
    typedef logic [7:0]  port_vec_t;
endpackage

/* File: rtl/override_bus_if.sv */
`timescale 1ns/10ps
interface override_bus_if;
    import pin_override_pkg::*;
    pin_vec_t pullup_override_en;
    pin_vec_t pullup_override_val;
    pin_vec_t direction_override_en;
    pin_vec_t direction_override_val;
    pin_vec_t out_value_override_en;
    pin_vec_t out_value_override_val;
    pin_vec_t pin_toggle_override_en;
    pin_vec_t input_buffer_override_en;
    pin_vec_t input_buffer_override_val;
    pin_vec_t port_out;
    pin_vec_t port_dir;
    logic     global_pullup_off;
    pin_vec_t next_pullup;
    pin_vec_t next_dir;
    pin_vec_t next_out_value;
    pin_vec_t next_toggle;
    pin_vec_t next_input_en;

    modport source (
        output pullup_override_en, pullup_override_val,
        output direction_override_en, direction_override_val,
        output out_value_override_en, out_value_override_val,
        output pin_toggle_override_en,
        output input_buffer_override_en, input_buffer_override_val,
        output port_out, port_dir, global_pullup_off,
        input  next_pullup, next_dir, next_out_value, next_toggle, next_input_en
    );
    modport select (
        input  pullup_override_en, pullup_override_val,
        input  direction_override_en, direction_override_val,
        input  out_value_override_en, out_value_override_val,
        input  pin_toggle_override_en,
        input  input_buffer_override_en, input_buffer_override_val,
        input  port_out, port_dir, global_pullup_off,
        output next_pullup, next_dir, next_out_value, next_toggle, next_input_en
    );
endinterface

/* File: rtl/override_select.sv */
`timescale 1ns/10ps
module override_select (
    override_bus_if.select ovr
);
    import pin_override_pkg::*;

    // ************************************************
    // per-pin choice between override and port register
    // ************************************************
    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_pin
            always_comb begin
                // register path pull-up: output bit high while pin is an input
                ovr.next_pullup[i]    = ovr.pullup_override_en[i] ?
                                        ovr.pullup_override_val[i] :
                                        (ovr.port_out[i] & ~ovr.port_dir[i]
                                         & ~ovr.global_pullup_off);
                ovr.next_dir[i]       = ovr.direction_override_en[i] ?
                                        ovr.direction_override_val[i] :
                                        ovr.port_dir[i];
                ovr.next_out_value[i] = ovr.out_value_override_en[i] ?
                                        ovr.out_value_override_val[i] :
                                        ovr.port_out[i];
                ovr.next_toggle[i]    = ovr.pin_toggle_override_en[i];
                ovr.next_input_en[i]  = ovr.input_buffer_override_en[i] ?
                                        ovr.input_buffer_override_val[i] :
                                        1'b1;
            end
        end
    endgenerate
endmodule // override_select

/* File: rtl/port_e_f_alt_function_override.sv */
`timescale 1ns/10ps
`include "pin_override_consts.svh"

// Contract
// - an enabled receiver makes port e bit 0 an input whatever its direction bit says.
// - while forced to input, e0 pulls up when its output bit is one, unless pull-ups are off.
// - port e bit 0 feeds pin-change source 0, its input enabled by mask and group enable.
// - a programmed clock-output fuse makes port e bit 7 an output carrying the i/o clock halved.
// - three-wire usi drives e6; pin change enables inputs on e7-e0, start detection on e5-e4.
// - two-wire usi overrides pull-up and direction on e5-e4, drives low, toggles e4.
// - transmitter makes e1 an unpulled tx output; e2 outputs the sync clock when enabled.
// - comparator input-disable turns off e3/e2 input buffers unless pin change is on there.
// - with the test port on, pull-ups on port f bits 7, 5 and 4 stay on, through reset too.
// - test port on takes f7-f4 from i/o: pull-up on, direction overridden, inputs off.
// - the test output pin drives only while shifting ir or dr, else it is pulled high.
// - test port traffic is timed by the test clock and steered by the tester.
// - port f bits 7-0 each feed the converter channel of the same number.
// - port f bits 3-0 receive no digital override at all.
module port_e_f_alt_function_override (
    input  wire logic                        clk,
    input  wire logic                        reset,
    input  wire pin_override_pkg::port_vec_t port_e_out,
    input  wire pin_override_pkg::port_vec_t port_e_dir,
    input  wire pin_override_pkg::port_vec_t port_f_out,
    input  wire pin_override_pkg::port_vec_t port_f_dir,
    input  wire logic                        global_pullup_off,
    input  wire pin_override_pkg::port_vec_t pin_change_mask,
    input  wire logic                        pin_change_group_enable,
    input  wire logic                        clock_output_fuse,
    input  wire logic                        receiver_on,
    input  wire logic                        transmitter_on,
    input  wire logic                        usart_tx_data,
    input  wire logic                        usart_sync_clock,
    input  wire logic                        usart_sync_clock_oe,
    input  wire logic                        usi_2wire_mode,
    input  wire logic                        usi_3wire_mode,
    input  wire logic                        usi_serial_out,
    input  wire logic                        usi_data_line_out,
    input  wire logic                        usi_clock_line_hold,
    input  wire logic                        usi_clock_toggle,
    input  wire logic                        usi_start_irq_enable,
    input  wire logic                        comparator_pos_input_disable,
    input  wire logic                        comparator_neg_input_disable,
    input  wire logic                        test_port_on,
    input  wire logic                        tap_shift_ir,
    input  wire logic                        tap_shift_dr,
    input  wire logic                        tap_data_out,
    output logic [15:0]                      pin_pullup,
    output logic [15:0]                      pin_dir,
    output logic [15:0]                      pin_out_value,
    output logic [15:0]                      pin_toggle,
    output logic [15:0]                      pin_input_en,
    output pin_override_pkg::port_vec_t      adc_channel_route
);
    import pin_override_pkg::*;

    // ************************************************
    // test-clock signals into the i/o clock domain
    // ************************************************
    // the tap runs on its own clock; its state and data pass two flops here
    // limitation: tap changes reach the pins three i/o clocks late
    logic [2:0] tap_meta;
    logic [2:0] tap_sync;
    logic [2:0] next_tap_meta;
    logic [2:0] next_tap_sync;

    always_comb begin
        next_tap_meta = {tap_data_out, tap_shift_dr, tap_shift_ir};
        next_tap_sync = tap_meta;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tap_meta <= 3'h0;
            tap_sync <= 3'h0;
        end else begin
            tap_meta <= next_tap_meta;
            tap_sync <= next_tap_sync;
        end
    end

    // ************************************************
    // i/o clock divider for the clock output pin
    // ************************************************
    // output pins must come from flops, so the clock leaves halved
    // trade-off: the pin stays flop-driven but never shows the full rate
    logic clk_div;
    logic next_clk_div;

    always_comb begin
        next_clk_div = ~clk_div;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            clk_div <= 1'b0;
        end else begin
            clk_div <= next_clk_div;
        end
    end

    // ************************************************
    // override enables and values
    // ************************************************
    override_bus_if ovr ();
    // later writes win, so a pin not named below keeps its register values

    logic [7:0] pc_on;

    always_comb begin
        pc_on = pin_change_mask & {8{pin_change_group_enable}};

        ovr.pullup_override_en        = `OVR_NONE;
        ovr.pullup_override_val       = `OVR_NONE;
        ovr.direction_override_en     = `OVR_NONE;
        ovr.direction_override_val    = `OVR_NONE;
        ovr.out_value_override_en     = `OVR_NONE;
        ovr.out_value_override_val    = `OVR_NONE;
        ovr.pin_toggle_override_en    = `OVR_NONE;
        ovr.input_buffer_override_en  = `OVR_NONE;
        ovr.input_buffer_override_val = `OVR_NONE;
        ovr.port_out                  = {port_f_out, port_e_out};
        ovr.port_dir                  = {port_f_dir, port_e_dir};
        ovr.global_pullup_off         = global_pullup_off;

        // receive pin
        ovr.pullup_override_en[`PIN_E_RX]       = receiver_on;
        ovr.pullup_override_val[`PIN_E_RX]      = port_e_out[`PIN_E_RX]
                                                  & ~global_pullup_off;
        ovr.direction_override_en[`PIN_E_RX]    = receiver_on;
        ovr.direction_override_val[`PIN_E_RX]   = 1'b0;

        // transmit pin
        ovr.pullup_override_en[`PIN_E_TX]       = transmitter_on;
        ovr.direction_override_en[`PIN_E_TX]    = transmitter_on;
        ovr.direction_override_val[`PIN_E_TX]   = 1'b1;
        ovr.out_value_override_en[`PIN_E_TX]    = transmitter_on;
        ovr.out_value_override_val[`PIN_E_TX]   = usart_tx_data;

        // usart sync clock
        ovr.out_value_override_en[`PIN_E_SYNC_CLK]  = usart_sync_clock_oe;
        ovr.out_value_override_val[`PIN_E_SYNC_CLK] = usart_sync_clock;

        // pin-change input enables on port e
        ovr.input_buffer_override_en[`PORT_E_MSB:`PORT_E_LSB]  = pc_on;
        ovr.input_buffer_override_val[`PORT_E_MSB:`PORT_E_LSB] = 8'hFF;
        ovr.input_buffer_override_en[`PIN_E_USI_DATA] = pc_on[`PIN_E_USI_DATA]
                                                        | usi_start_irq_enable;
        ovr.input_buffer_override_en[`PIN_E_USI_CLK]  = pc_on[`PIN_E_USI_CLK]
                                                        | usi_start_irq_enable;

        // comparator inputs: disable wins unless pin change needs the pin
        ovr.input_buffer_override_en[`PIN_E_CMP_NEG]  = pc_on[`PIN_E_CMP_NEG]
                                                 | comparator_neg_input_disable;
        ovr.input_buffer_override_val[`PIN_E_CMP_NEG] = pc_on[`PIN_E_CMP_NEG];
        ovr.input_buffer_override_en[`PIN_E_SYNC_CLK] = pc_on[`PIN_E_SYNC_CLK]
                                                 | comparator_pos_input_disable;
        ovr.input_buffer_override_val[`PIN_E_SYNC_CLK] = pc_on[`PIN_E_SYNC_CLK];

        // usi_2wire_mode: open-drain style, drive low only
        ovr.pullup_override_en[`PIN_E_USI_DATA]     = usi_2wire_mode;
        ovr.pullup_override_en[`PIN_E_USI_CLK]      = usi_2wire_mode;
        ovr.direction_override_en[`PIN_E_USI_DATA]  = usi_2wire_mode;
        ovr.direction_override_val[`PIN_E_USI_DATA] = (~usi_data_line_out
                              | ~port_e_out[`PIN_E_USI_DATA])
                              & port_e_dir[`PIN_E_USI_DATA];
        ovr.direction_override_en[`PIN_E_USI_CLK]   = usi_2wire_mode;
        ovr.direction_override_val[`PIN_E_USI_CLK]  = (~usi_clock_line_hold
                              | ~port_e_out[`PIN_E_USI_CLK])
                              & port_e_dir[`PIN_E_USI_CLK];
        ovr.out_value_override_en[`PIN_E_USI_DATA]  = usi_2wire_mode
                              & port_e_dir[`PIN_E_USI_DATA];
        ovr.out_value_override_en[`PIN_E_USI_CLK]   = usi_2wire_mode
                              & port_e_dir[`PIN_E_USI_CLK];
        ovr.pin_toggle_override_en[`PIN_E_USI_CLK]  = usi_clock_toggle;

        // usi_3wire_mode serial output
        ovr.out_value_override_en[`PIN_E_USI_OUT]   = usi_3wire_mode;
        ovr.out_value_override_val[`PIN_E_USI_OUT]  = usi_serial_out;

        // clock output
        ovr.direction_override_en[`PIN_E_CLK_OUT]   = clock_output_fuse;
        ovr.direction_override_val[`PIN_E_CLK_OUT]  = 1'b1;
        ovr.out_value_override_en[`PIN_E_CLK_OUT]   = clock_output_fuse;
        ovr.out_value_override_val[`PIN_E_CLK_OUT]  = clk_div;

        // test port takes port f bits 7-4
        ovr.pullup_override_en[`PORT_F_MSB:`PIN_F_TCK]       = {4{test_port_on}};
        ovr.pullup_override_val[`PORT_F_MSB:`PIN_F_TCK]      = 4'hF;
        ovr.direction_override_en[`PORT_F_MSB:`PIN_F_TCK]    = {4{test_port_on}};
        ovr.input_buffer_override_en[`PORT_F_MSB:`PIN_F_TCK] = {4{test_port_on}};
        ovr.direction_override_val[`PIN_F_TDO] = tap_sync[0] | tap_sync[1];
        ovr.out_value_override_en[`PIN_F_TDO]  = test_port_on;
        ovr.out_value_override_val[`PIN_F_TDO] = tap_sync[2];
    end

    override_select u_select (
        .ovr (ovr.select)
    );

    // ************************************************
    // registered pin attributes
    // ************************************************
    // pull-ups of the test pins other than tdo (f7, f5, f4) reset on so the tester keeps a defined level
    // the converter route is fixed; it sits in a flop only so every output is registered
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_pullup        <= `RST_PULLUP;
            pin_dir           <= `RST_DIR;
            pin_out_value     <= `RST_OUT_VALUE;
            pin_toggle        <= `RST_TOGGLE;
            pin_input_en      <= `RST_INPUT_EN;
            adc_channel_route <= `RST_ADC_ROUTE;
        end else begin
            pin_pullup        <= ovr.next_pullup;
            pin_dir           <= ovr.next_dir;
            pin_out_value     <= ovr.next_out_value;
            pin_toggle        <= ovr.next_toggle;
            pin_input_en      <= ovr.next_input_en;
            adc_channel_route <= `RST_ADC_ROUTE;
        end
    end
endmodule // port_e_f_alt_function_override

/* File: testbench/pin_board.sv */
`timescale 1ns/10ps
// ************************
// board side of the pins
// ************************
module pin_board (
    input wire logic        clk,
    input wire logic [15:0] pin_pullup,
    input wire logic [15:0] pin_dir,
    input wire logic [15:0] pin_out_value,
    output logic [15:0]     pin_level
);
    // a floating pin flips every cycle so a stale level never passes for a driven one
    logic flip = 1'b0;
    always @(posedge clk) flip <= ~flip;
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            pin_level[i] = pin_dir[i] ? pin_out_value[i] : (pin_pullup[i] | flip);
        end
    end
endmodule // pin_board

/* File: testbench/pin_override_props.sv */
`timescale 1ns/10ps
// ****************
// override checks
// ****************
module pin_override_props
    import pin_override_pkg::*;
(
    input wire logic                        clk,
    input wire logic                        reset,
    input wire logic                        receiver_on,
    input wire pin_override_pkg::port_vec_t port_e_out,
    input wire logic                        global_pullup_off,
    input wire logic                        transmitter_on,
    input wire logic                        usart_tx_data,
    input wire logic                        clock_output_fuse,
    input wire logic                        usi_3wire_mode,
    input wire logic                        usi_serial_out,
    input wire logic                        test_port_on,
    input wire logic                        tap_shift_ir,
    input wire logic                        tap_shift_dr,
    input wire pin_override_pkg::port_vec_t port_f_out,
    input wire pin_override_pkg::port_vec_t port_f_dir,
    input wire logic [15:0]                 pin_pullup,
    input wire logic [15:0]                 pin_dir,
    input wire logic [15:0]                 pin_out_value,
    input wire logic [15:0]                 pin_input_en
);
    // edges since reset left; $past looks back into reset otherwise
    logic [1:0] age;
    logic [1:0] next_age;
    wire        live  = age != 2'h0;
    wire        live3 = age == 2'h3;
    always_comb begin
        next_age = (age == 2'h3) ? age : age + 2'h1;
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) age <= 2'h0;
        else age <= next_age;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_rx_dir; live && $past(receiver_on) |-> !pin_dir[0]; endproperty
    a_rx_dir: assert property (p_rx_dir) else $error("rx pin not input");
    property p_rx_pull;
        live && $past(receiver_on) |-> pin_pullup[0] == $past(port_e_out[0] & ~global_pullup_off);
    endproperty
    a_rx_pull: assert property (p_rx_pull) else $error("rx pullup wrong");
    property p_tx;
        live && $past(transmitter_on) |->
            pin_dir[1] && !pin_pullup[1] && pin_out_value[1] == $past(usart_tx_data);
    endproperty
    a_tx: assert property (p_tx) else $error("tx pin wrong");
    property p_clk_out;
        live3 && $past(clock_output_fuse) && $past(clock_output_fuse, 2) |->
            pin_dir[7] && pin_out_value[7] != $past(pin_out_value[7]);
    endproperty
    a_clk_out: assert property (p_clk_out) else $error("clock out not toggling");
    property p_usi_out;
        live && $past(usi_3wire_mode) |-> pin_out_value[6] == $past(usi_serial_out);
    endproperty
    a_usi_out: assert property (p_usi_out) else $error("usi output wrong");
    property p_tap_pins;
        live && $past(test_port_on) |-> pin_pullup[15:12] == 4'hF && pin_input_en[15:12] == 4'h0;
    endproperty
    a_tap_pins: assert property (p_tap_pins) else $error("tap pins not taken");
    property p_reset_pull;
        disable iff (1'b0) reset && $past(reset) |-> pin_pullup[15:12] == 4'hB;
    endproperty
    a_reset_pull: assert property (p_reset_pull) else $error("reset pullups off");
    property p_tdo_dir;
        live3 && $past(test_port_on) |->
            pin_dir[14] == ($past(tap_shift_ir, 3) | $past(tap_shift_dr, 3));
    endproperty
    a_tdo_dir: assert property (p_tdo_dir) else $error("tdo drive wrong");
    property p_f_low;
        live |-> pin_dir[11:8] == $past(port_f_dir[3:0])
            && pin_out_value[11:8] == $past(port_f_out[3:0]);
    endproperty
    a_f_low: assert property (p_f_low) else $error("port f low overridden");
    c_rx: cover property (live && $past(receiver_on) && pin_pullup[0]);
    c_tdo: cover property (pin_dir[14]);
    c_clk: cover property (pin_dir[7]);
endmodule // pin_override_props
bind port_e_f_alt_function_override pin_override_props pin_override_props_i (
    .clk, .reset, .receiver_on, .port_e_out, .global_pullup_off, .transmitter_on,
    .usart_tx_data, .clock_output_fuse, .usi_3wire_mode, .usi_serial_out, .test_port_on,
    .tap_shift_ir, .tap_shift_dr, .port_f_out, .port_f_dir, .pin_pullup, .pin_dir,
    .pin_out_value, .pin_input_en);

/* File: testbench/port_e_f_alt_function_override_tb_top.sv */
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
// ***********
// bench top
// ***********
module port_e_f_alt_function_override_tb_top;
    import pin_override_pkg::*;
    int          fails;
    int          checks;
    logic        clk, reset, global_pullup_off, pin_change_group_enable, clock_output_fuse;
    logic        receiver_on, transmitter_on, usart_tx_data, usart_sync_clock;
    logic        usart_sync_clock_oe, usi_2wire_mode, usi_3wire_mode, usi_serial_out;
    logic        usi_data_line_out, usi_clock_line_hold, usi_clock_toggle, usi_start_irq_enable;
    logic        comparator_pos_input_disable, comparator_neg_input_disable;
    logic        test_port_on, tap_shift_ir, tap_shift_dr, tap_data_out, v;
    port_vec_t   port_e_out, port_e_dir, port_f_out, port_f_dir, pin_change_mask;
    logic [15:0] pin_pullup, pin_dir, pin_out_value, pin_toggle, pin_input_en, pin_level;
    port_vec_t   adc_channel_route;
    port_e_f_alt_function_override port_e_f_alt_function_override_i (.clk, .reset,
        .port_e_out, .port_e_dir, .port_f_out, .port_f_dir, .global_pullup_off,
        .pin_change_mask, .pin_change_group_enable, .clock_output_fuse, .receiver_on,
        .transmitter_on, .usart_tx_data, .usart_sync_clock, .usart_sync_clock_oe,
        .usi_2wire_mode, .usi_3wire_mode, .usi_serial_out, .usi_data_line_out,
        .usi_clock_line_hold, .usi_clock_toggle, .usi_start_irq_enable,
        .comparator_pos_input_disable, .comparator_neg_input_disable, .test_port_on,
        .tap_shift_ir, .tap_shift_dr, .tap_data_out, .pin_pullup, .pin_dir, .pin_out_value,
        .pin_toggle, .pin_input_en, .adc_channel_route);
    pin_board pin_board_i (.clk, .pin_pullup, .pin_dir, .pin_out_value, .pin_level);
    always #12.5 clk = ~clk;
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic t_rx;
        @(posedge clk) {receiver_on, port_e_dir[0], port_e_out[0]} <= 3'h7;
        settle(1);
        `CHK("rx dir", 1'b0, pin_dir[0])
        `CHK("rx pullup", 1'b1, pin_pullup[0])
        @(posedge clk) global_pullup_off <= 1'b1;
        settle(1);
        `CHK("rx pullup off", 1'b0, pin_pullup[0])
        @(posedge clk) {receiver_on, global_pullup_off} <= 2'h0;
        settle(1);
        `CHK("rx released", 1'b1, pin_dir[0])
        $display("test rx done");
    endtask
    task automatic t_tx;
        @(posedge clk) {transmitter_on, usart_tx_data, port_e_out[1]} <= 3'h7;
        {usart_sync_clock_oe, usart_sync_clock} <= 2'h3;
        settle(1);
        `CHK("tx pins", 4'hB, {pin_dir[1], pin_pullup[1], pin_out_value[2:1]})
        @(posedge clk) {transmitter_on, usart_sync_clock_oe} <= 2'h0;
        settle(1);
        `CHK("tx released", 2'h1, {pin_dir[1], pin_pullup[1]})
        $display("test tx done");
    endtask
    task automatic t_usi;
        @(posedge clk) {usi_3wire_mode, usi_serial_out} <= 2'h3;
        settle(1);
        `CHK("usi out", 1'b1, pin_out_value[6])
        @(posedge clk) {usi_3wire_mode, usi_2wire_mode, usi_clock_toggle} <= 3'h3;
        {port_e_dir[5], port_e_out[5]} <= 2'h3;
        settle(1);
        `CHK("two-wire dir out", 2'h2, {pin_dir[5], pin_out_value[5]})
        `CHK("two-wire pull tog", 2'h1, {pin_pullup[5], pin_toggle[4]})
        @(posedge clk) usi_data_line_out <= 1'b1;
        settle(1);
        `CHK("two-wire release", 1'b0, pin_dir[5])
        @(posedge clk) {usi_2wire_mode, usi_clock_toggle} <= 2'h0;
        $display("test usi done");
    endtask
    task automatic t_cmp;
        @(posedge clk) {comparator_neg_input_disable, comparator_pos_input_disable} <= 2'h3;
        settle(1);
        `CHK("cmp inputs off", 2'h0, pin_input_en[3:2])
        @(posedge clk) {pin_change_mask, pin_change_group_enable} <= 9'h017;
        settle(1);
        `CHK("cmp pin change", 2'h2, pin_input_en[3:2])
        @(posedge clk) pin_change_group_enable <= 1'b0;
        settle(1);
        `CHK("pin change group off", 2'h1, {pin_input_en[3], pin_input_en[0]})
        $display("test cmp done");
    endtask
    task automatic t_clk;
        @(posedge clk) clock_output_fuse <= 1'b1;
        settle(1);
        v = pin_out_value[7];
        `CHK("clk out dir", 1'b1, pin_dir[7])
        settle(1);
        `CHK("clk out toggles", ~v, pin_out_value[7])
        @(posedge clk) clock_output_fuse <= 1'b0;
        $display("test clkout done");
    endtask
    task automatic t_tap;
        // port f outputs set once here and left alone while the converter may sample
        @(posedge clk) {port_f_dir, port_f_out} <= 16'hFFF5;
        {test_port_on, tap_data_out} <= 2'h3;
        settle(3);
        `CHK("tap pullups", 8'hF0, {pin_pullup[15:12], pin_input_en[15:12]})
        `CHK("tap dirs", 4'h0, pin_dir[15:12])
        `CHK("f low", 12'h0F5, {pin_pullup[11:8], pin_dir[11:8], pin_out_value[11:8]})
        `CHK("tdo idle high", 1'b1, pin_level[14])
        @(posedge clk) tap_shift_dr <= 1'b1;
        settle(3);
        `CHK("tdo shift dr", 2'h3, {pin_dir[14], pin_out_value[14]})
        @(posedge clk) {tap_shift_dr, tap_shift_ir, tap_data_out} <= 3'h2;
        settle(3);
        `CHK("tdo shift ir", 2'h2, {pin_dir[14], pin_out_value[14]})
        @(posedge clk) reset <= 1'b1;
        settle(1);
        `CHK("reset tap pullups", 4'hB, pin_pullup[15:12])
        @(posedge clk) reset <= 1'b0;
        $display("test tap done");
    endtask
    task automatic final_report;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        {clk, global_pullup_off, pin_change_group_enable, clock_output_fuse, receiver_on,
         transmitter_on, usart_tx_data, usart_sync_clock, usart_sync_clock_oe, usi_2wire_mode,
         usi_3wire_mode, usi_serial_out, usi_data_line_out, usi_clock_line_hold,
         usi_clock_toggle, usi_start_irq_enable, comparator_pos_input_disable,
         comparator_neg_input_disable, test_port_on, tap_shift_ir, tap_shift_dr, tap_data_out,
         port_e_out, port_e_dir, port_f_out, port_f_dir, pin_change_mask} = '0;
        reset = 1'b1;
        settle(4);
        `CHK("reset pullups", 16'hB000, pin_pullup)
        `CHK("reset input en", 24'h00FFFF, {pin_input_en, adc_channel_route})
        @(posedge clk) reset <= 1'b0;
        t_rx;
        t_tx;
        t_usi;
        t_cmp;
        t_clk;
        t_tap;
        final_report;
    end
    initial begin
        #100000;
        fails++;
        final_report;
    end
endmodule // port_e_f_alt_function_override_tb_top
